/* File: async_serial_port_defines.svh */
// constants for the asynchronous serial port: widths, counts, reset values
// assumes inclusion by bare name from the package file
`ifndef ASYNC_SERIAL_PORT_DEFINES_SVH
`define ASYNC_SERIAL_PORT_DEFINES_SVH

// ==========================================================
// widths
`define ASP_DATA_W        8
`define ASP_WORD_W        9
`define ASP_SHIFT_W       11
`define ASP_DIV_W         16
`define ASP_BITCNT_W      4
// ==========================================================
// timing counts
`define ASP_OVERSAMPLE    5'd16
`define ASP_PHASE_LAST    4'hf
`define ASP_SAMPLE_A      4'h7
`define ASP_SAMPLE_B      4'h8
`define ASP_SAMPLE_C      4'h9
`define ASP_FRAME_BITS_8  4'ha
`define ASP_FRAME_BITS_9  4'hb
`define ASP_IDLE_TICKS_8  8'ha0
`define ASP_IDLE_TICKS_9  8'hb0
// ==========================================================
// reset values, break pattern and buffer depth
`define ASP_DIV_RESET     16'h0000
`define ASP_SHIFT_IDLE    11'h7ff
`define ASP_SHIFT_BREAK   11'h000
`define ASP_BUF_DEPTH     2

`endif

/* File: async_serial_port_pkg.sv */
// types shared by the asynchronous serial port files
// assumes the defines header is on the include path
`include "async_serial_port_defines.svh"

package async_serial_port_pkg;
  typedef logic [`ASP_DATA_W-1:0]  byte_t;
  typedef logic [`ASP_WORD_W-1:0]  word_t;
  typedef logic [`ASP_SHIFT_W-1:0] shift_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_FRAME = 3'b010,
    RX_WAIT  = 3'b100
  } rx_state_t;
endpackage

/* File: async_serial_skid_buffer.sv */
// two-entry buffer with valid/ready on both sides
// assumes one clock and synchronous active-high reset
`timescale 1ns/1ps

module async_serial_skid_buffer (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // fill side
  input  wire logic                        in_valid,
  output logic                             in_ready,
  input  wire async_serial_port_pkg::word_t in_data,
  // drain side
  output logic                             out_valid,
  input  wire logic                        out_ready,
  output async_serial_port_pkg::word_t     out_data
);
  import async_serial_port_pkg::*;

  word_t      entry [`ASP_BUF_DEPTH];
  logic       rd_ptr;
  logic       wr_ptr;
  logic [1:0] count;
  logic       push;
  logic       pop;

  assign in_ready  = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data  = entry[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // ==========================================================
  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      entry[wr_ptr] <= in_data;
    end
  end

  // ==========================================================
  // pointers and fill level
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count  <= 2'd0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push && !pop) begin
        count <= count + 2'd1;
      end else if (pop && !push) begin
        count <= count - 2'd1;
      end
    end
  end
endmodule // async_serial_skid_buffer

/* File: async_serial_port.sv */
// full-duplex asynchronous serial port: transmitter, receiver, bit-rate divider
// assumes all control inputs synchronous to clk; data port accesses are pulses
`timescale 1ns/1ps

module async_serial_port (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // shared format and rate
  input  wire logic [`ASP_DIV_W-1:0]        baud_div,
  input  wire logic                         nine_bit_mode,
  // transmitter control
  input  wire logic                         tx_enable,
  input  wire logic                         send_break,
  input  wire logic                         tx_ninth_bit,
  // receiver control
  input  wire logic                         rx_enable,
  input  wire logic                         rx_standby_set,
  input  wire logic                         wake_on_address,
  // serial data register
  input  wire logic                         data_write,
  input  wire async_serial_port_pkg::byte_t data_wdata,
  input  wire logic                         data_read,
  output async_serial_port_pkg::byte_t      rx_buffer,
  output logic                              rx_ninth_bit,
  // status
  output logic                              tx_buffer_empty_flag,
  output logic                              tx_complete_flag,
  output logic                              rx_full_flag,
  output logic                              overrun_flag,
  output logic                              noise_flag,
  output logic                              framing_error_flag,
  output logic                              rx_standby,
  // serial lines
  output logic                              txd,
  input  wire logic                         rxd
);
  import async_serial_port_pkg::*;

  // ==========================================================
  // bit-rate divider
  logic [`ASP_DIV_W-1:0]    div_cnt;
  logic                     tick16;
  logic [3:0]               tx_phase;
  logic                     tx_tick;

  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt <= `ASP_DIV_RESET;
      tick16  <= 1'b0;
    end else if (div_cnt >= baud_div) begin
      div_cnt <= `ASP_DIV_RESET;
      tick16  <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      tick16  <= 1'b0;
    end
  end

  // transmit bit rate is one sixteenth of sample rate
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_phase <= 4'h0;
    end else if (tick16) begin
      tx_phase <= tx_phase + 4'h1;
    end
  end
  assign tx_tick = tick16 && (tx_phase == `ASP_PHASE_LAST);

  // ==========================================================
  // transmitter
  tx_state_t                tx_state;
  shift_t                   tx_shift;
  logic [`ASP_BITCNT_W-1:0] tx_bits;
  word_t                    tx_buffer;
  logic                     tx_enable_q;
  logic                     preamble_pending;
  logic                     tx_load_data;
  logic                     tx_load_any;
  logic                     tx_last_bit;
  logic [`ASP_BITCNT_W-1:0] frame_bits;

  // one format control for both directions
  assign frame_bits   = nine_bit_mode ? `ASP_FRAME_BITS_9 : `ASP_FRAME_BITS_8;
  assign tx_last_bit  = (tx_state == TX_SHIFT) && tx_tick && (tx_bits == frame_bits - 4'h1);
  assign tx_load_any  = tx_enable && tx_tick && ((tx_state == TX_IDLE) || tx_last_bit) &&
                        (preamble_pending || send_break || !tx_buffer_empty_flag);
  assign tx_load_data = tx_load_any && !preamble_pending && !send_break;

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_enable_q      <= 1'b0;
      preamble_pending <= 1'b0;
    end else begin
      tx_enable_q <= tx_enable;
      if (tx_enable && !tx_enable_q) begin
        preamble_pending <= 1'b1;
      end else if (tx_load_any) begin
        preamble_pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_buffer <= '0;
    end else if (data_write) begin
      tx_buffer <= {tx_ninth_bit, data_wdata};
    end
  end

  // buffer-empty set on move, cleared by write
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_buffer_empty_flag <= 1'b1;
    end else if (data_write) begin
      tx_buffer_empty_flag <= 1'b0;
    end else if (tx_load_data) begin
      tx_buffer_empty_flag <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_state <= TX_IDLE;
      tx_shift <= `ASP_SHIFT_IDLE;
      tx_bits  <= '0;
    end else if (tx_load_any) begin
      tx_state <= TX_SHIFT;
      tx_bits  <= '0;
      if (preamble_pending) begin
        tx_shift <= `ASP_SHIFT_IDLE;
      end else if (send_break) begin
        tx_shift <= `ASP_SHIFT_BREAK;
      end else if (nine_bit_mode) begin
        tx_shift <= {1'b1, tx_buffer, 1'b0};
      end else begin
        tx_shift <= {2'b11, tx_buffer[`ASP_DATA_W-1:0], 1'b0};
      end
    end else if (tx_last_bit) begin
      tx_state <= TX_IDLE;
      tx_shift <= `ASP_SHIFT_IDLE;
    end else if (tx_state == TX_SHIFT && tx_tick) begin
      tx_shift <= {1'b1, tx_shift[`ASP_SHIFT_W-1:1]};
      tx_bits  <= tx_bits + 4'h1;
    end
  end

  // line idles high whenever nothing shifts
  always_ff @(posedge clk) begin
    if (rst) begin
      txd <= 1'b1;
    end else if (tx_load_any) begin
      txd <= preamble_pending || (!send_break && 1'b0);
    end else if (tx_state == TX_SHIFT && tx_tick && !tx_last_bit) begin
      txd <= tx_shift[1];
    end else if (tx_state == TX_IDLE || tx_last_bit) begin
      txd <= 1'b1;
    end
  end

  // complete when last bit ends with nothing waiting
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_complete_flag <= 1'b1;
    end else if (tx_last_bit && !tx_load_any) begin
      tx_complete_flag <= 1'b1;
    end else if (data_write || tx_load_any || (tx_enable && !tx_enable_q)) begin
      tx_complete_flag <= 1'b0;
    end
  end

  // ==========================================================
  // receiver data recovery
  rx_state_t                rx_state;
  logic                     rxd_q;
  logic [3:0]               rx_phase;
  logic [2:0]               samples;
  logic                     bit_done;
  logic                     bit_val;
  logic                     bit_noisy;
  logic [`ASP_BITCNT_W-1:0] rx_bits;
  word_t                    rx_shift;
  logic [7:0]               idle_cnt;
  logic                     fall;
  logic                     frame_done;
  logic                     frame_ok_stop;
  word_t                    frame_word;
  logic                     frame_addr;
  logic                     buf_in_valid;
  logic                     buf_in_ready;
  logic                     buf_out_valid;
  word_t                    buf_out_data;

  assign fall      = tick16 && rxd_q && !rxd;
  assign bit_done  = tick16 && (rx_phase == `ASP_SAMPLE_C) && (rx_state == RX_FRAME);
  assign bit_val   = (samples[0] & samples[1]) | (samples[0] & rxd) | (samples[1] & rxd);
  assign bit_noisy = !((samples[0] == samples[1]) && (samples[1] == rxd));
  assign frame_done = bit_done && (rx_bits == frame_bits - 4'h1);
  assign frame_ok_stop = bit_val;
  assign frame_word = nine_bit_mode ? rx_shift : {1'b0, rx_shift[`ASP_WORD_W-1:1]};
  assign frame_addr = nine_bit_mode ? rx_shift[`ASP_WORD_W-1] : rx_shift[`ASP_WORD_W-1];

  always_ff @(posedge clk) begin
    if (rst) begin
      rxd_q <= 1'b1;
    end else if (tick16) begin
      rxd_q <= rxd;
    end
  end

  // phase restarts on each falling edge
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_phase <= 4'h0;
    end else if (fall) begin
      rx_phase <= 4'h1;
    end else if (tick16) begin
      rx_phase <= rx_phase + 4'h1;
    end
  end

  // samples at phases seven and eight, third taken live at nine
  always_ff @(posedge clk) begin
    if (rst) begin
      samples <= 3'b111;
    end else if (tick16 && rx_phase == `ASP_SAMPLE_A) begin
      samples[0] <= rxd;
    end else if (tick16 && rx_phase == `ASP_SAMPLE_B) begin
      samples[1] <= rxd;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !rx_enable) begin
      rx_state <= RX_IDLE;
      rx_bits  <= '0;
      rx_shift <= '0;
    end else begin
      unique case (rx_state)
        RX_IDLE: begin
          if (fall) begin
            rx_state <= RX_FRAME;
            rx_bits  <= '0;
          end
        end
        RX_FRAME: begin
          if (bit_done) begin
            if (rx_bits == 4'h0 && bit_val) begin
              rx_state <= RX_IDLE;
            end else if (frame_done) begin
              rx_state <= bit_val ? RX_IDLE : RX_WAIT;
            end else begin
              rx_bits <= rx_bits + 4'h1;
              if (rx_bits != 4'h0) begin
                rx_shift <= {bit_val, rx_shift[`ASP_WORD_W-1:1]};
              end
            end
          end
        end
        RX_WAIT: begin
          // broken stop bit: hold off until line returns high
          if (tick16 && rxd) begin
            rx_state <= RX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_standby <= 1'b0;
      idle_cnt   <= 8'h00;
    end else begin
      if (!tick16) begin
        idle_cnt <= idle_cnt;
      end else if (!rxd) begin
        idle_cnt <= 8'h00;
      end else if (idle_cnt != 8'hff) begin
        idle_cnt <= idle_cnt + 8'h01;
      end
      if (rx_standby_set) begin
        rx_standby <= 1'b1;
      end else if (rx_standby && !wake_on_address &&
                   idle_cnt == (nine_bit_mode ? `ASP_IDLE_TICKS_9 : `ASP_IDLE_TICKS_8)) begin
        rx_standby <= 1'b0;
      end else if (rx_standby && wake_on_address && frame_done && frame_addr) begin
        rx_standby <= 1'b0;
      end
    end
  end

  // address character that wakes the receiver is delivered too
  assign buf_in_valid = frame_done && (!rx_standby || (wake_on_address && frame_addr));

  // stall by an unread buffer holds words; full buffer is overrun
  async_serial_skid_buffer u_rx_skid (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (nine_bit_mode ? {rx_shift[`ASP_WORD_W-1], rx_shift[`ASP_WORD_W-2:0]} : frame_word),
    .out_valid (buf_out_valid),
    .out_ready (!rx_full_flag),
    .out_data  (buf_out_data)
  );

  // receive buffer and full flag; read clears
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_buffer    <= '0;
      rx_ninth_bit <= 1'b0;
      rx_full_flag <= 1'b0;
    end else if (buf_out_valid && !rx_full_flag) begin
      rx_buffer    <= buf_out_data[`ASP_DATA_W-1:0];
      rx_ninth_bit <= buf_out_data[`ASP_WORD_W-1];
      rx_full_flag <= 1'b1;
    end else if (data_read) begin
      rx_full_flag <= 1'b0;
    end
  end

  // error flags: set wins over read clear
  always_ff @(posedge clk) begin
    if (rst) begin
      overrun_flag       <= 1'b0;
      noise_flag         <= 1'b0;
      framing_error_flag <= 1'b0;
    end else begin
      if (buf_in_valid && !buf_in_ready) begin
        overrun_flag <= 1'b1;
      end else if (data_read) begin
        overrun_flag <= 1'b0;
      end
      if (bit_done && bit_noisy && !rx_standby) begin
        noise_flag <= 1'b1;
      end else if (data_read) begin
        noise_flag <= 1'b0;
      end
      if (frame_done && !frame_ok_stop && !rx_standby) begin
        framing_error_flag <= 1'b1;
      end else if (data_read) begin
        framing_error_flag <= 1'b0;
      end
    end
  end
endmodule // async_serial_port

/* File: async_serial_port_spacer.sv */
// holds no logic; kept so the file list stays fixed
`timescale 1ns/1ps

/* File: async_serial_port_props.sv */
// checker on the serial port top-level ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps

module async_serial_port_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // controls
  input wire logic tx_enable,
  input wire logic nine_bit_mode,
  input wire logic data_write,
  input wire logic data_read,
  input wire logic rx_standby_set,
  // status and line
  input wire logic tx_buffer_empty_flag,
  input wire logic tx_complete_flag,
  input wire logic rx_full_flag,
  input wire logic overrun_flag,
  input wire logic rx_ninth_bit,
  input wire logic rx_standby,
  input wire logic txd
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff rst;
  // ====================
  // sequences
  sequence s_load;
    !txd && tx_buffer_empty_flag && !tx_complete_flag;
  endsequence
  // txd holds for at least eight clocks after a change
  sequence s_hold_bit;
    $stable(txd) [*8];
  endsequence
  // ====================
  // properties
  property p_reset_idle;
    $fell(rst) |-> txd && tx_buffer_empty_flag && tx_complete_flag && !rx_full_flag && !overrun_flag;
  endproperty
  property p_write_fills;
    data_write |=> !tx_buffer_empty_flag;
  endproperty
  property p_load_frame;
    $rose(tx_buffer_empty_flag) && !$past(rst) |-> s_load;
  endproperty
  property p_complete_idle;
    $rose(tx_complete_flag) && !$past(rst) |-> txd && tx_buffer_empty_flag;
  endproperty
  property p_complete_clear;
    $fell(tx_complete_flag) |-> $past(data_write) || !txd || ($past(tx_enable) && !$past(tx_enable, 2));
  endproperty
  property p_read_clears;
    $fell(rx_full_flag) && !$past(rst) |-> $past(data_read);
  endproperty
  property p_overrun_full;
    $rose(overrun_flag) |-> rx_full_flag;
  endproperty
  property p_bit_hold;
    $changed(txd) && !$past(rst) |=> s_hold_bit;
  endproperty
  property p_standby_enter;
    rx_standby_set |=> rx_standby;
  endproperty
  property p_ninth_clear;
    $rose(rx_full_flag) && !nine_bit_mode |-> !rx_ninth_bit;
  endproperty
  // ====================
  // assertions
  a_reset_idle: assert property (p_reset_idle) else $error("port not idle after reset");
  a_write_fills: assert property (p_write_fills) else $error("write left buffer empty");
  a_load_frame: assert property (p_load_frame) else $error("load without start bit");
  a_complete_idle: assert property (p_complete_idle) else $error("complete while busy");
  a_complete_clear: assert property (p_complete_clear) else $error("complete dropped alone");
  a_read_clears: assert property (p_read_clears) else $error("full dropped without read");
  a_overrun_full: assert property (p_overrun_full) else $error("overrun with empty buffer");
  a_bit_hold: assert property (p_bit_hold) else $error("transmit bit too short");
  a_standby_enter: assert property (p_standby_enter) else $error("standby not entered");
  a_ninth_clear: assert property (p_ninth_clear) else $error("ninth bit set in 8-bit mode");
endmodule // async_serial_port_props

bind async_serial_port async_serial_port_props async_serial_port_props_inst (
  .clk, .rst, .tx_enable, .nine_bit_mode, .data_write, .data_read, .rx_standby_set, .tx_buffer_empty_flag,
  .tx_complete_flag, .rx_full_flag, .overrun_flag, .rx_ninth_bit, .rx_standby, .txd
);

/* File: remote_serial_model.sv */
// remote serial device: decodes txd frames and sends frames on rxd
// assumes idle-high lines and a bit length fixed in clocks
`timescale 1ns/1ps

module remote_serial_model #(
  parameter int BIT_CLKS = 16
) (
  // clock
  input  wire logic       clk,
  // line from the port
  input  wire logic       txd,
  input  wire logic       nine_bit,
  // line to the port
  output logic            rxd,
  // decoded character: stop, ninth, data
  output logic            seen_valid,
  output logic [9:0]      seen_word
);
  logic [9:0] v;

  initial begin
    rxd = 1'b1;
    seen_valid = 1'b0;
    seen_word = 10'h000;
  end
  // ====================
  // receiver, sampling at bit centre
  // start, lsb first, stop
  always begin
    @(negedge txd);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < (nine_bit ? 10 : 9); i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      v[i] = txd;
    end
    seen_word <= nine_bit ? v : {v[8], 1'b0, v[7:0]};
    seen_valid <= 1'b1;
    @(posedge clk);
    seen_valid <= 1'b0;
    // a break keeps the line low past its stop position
    wait (txd === 1'b1);
  end
  // ====================
  // transmitter, optionally slow, noisy or with a bad stop
  // frame with optional faults
  task automatic send(input logic [8:0] w, input logic nine, input int len, input logic glitch,
                      input logic bad_stop);
    logic [10:0] f;
    f = nine ? {~bad_stop, w, 1'b0} : {1'b1, ~bad_stop, w[7:0], 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      rxd <= f[i];
      repeat (8) @(posedge clk);
      if (glitch && i == 1) rxd <= ~f[i];
      @(posedge clk);
      rxd <= f[i];
      repeat (len - 9) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (len) @(posedge clk);
  endtask
endmodule // remote_serial_model

/* File: tb_async_serial_port.sv */
// self-checking bench for the asynchronous serial port
// assumes the design package and the remote model are compiled first
`timescale 1ns/1ps
`define CHECK(nm, ex, gt) begin \
  samples_checked++; \
  if ((gt) !== (ex)) begin err_count++; $display("ERROR %s expected %h seen %h", nm, ex, gt); end \
end

module tb_async_serial_port;
  import async_serial_port_pkg::*;
  localparam int BIT = 16;
  // ====================
  // design signals
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        nine_bit_mode = 1'b0;
  logic        tx_enable = 1'b0;
  logic        send_break = 1'b0;
  logic        tx_ninth_bit = 1'b0;
  logic        rx_enable = 1'b0;
  logic        rx_standby_set = 1'b0;
  logic        wake_on_address = 1'b0;
  logic        data_write = 1'b0;
  byte_t       data_wdata = 8'h00;
  logic        data_read = 1'b0;
  byte_t       rx_buffer;
  logic        rx_ninth_bit, tx_buffer_empty_flag, tx_complete_flag, rx_full_flag, overrun_flag;
  logic        noise_flag, framing_error_flag, rx_standby, txd, rxd, seen_valid;
  logic [9:0]  seen_word;
  // ====================
  // scoreboard
  logic [9:0]  tx_q[$];
  logic [10:0] rx_q[$];
  logic [9:0]  exp_tx;
  logic [10:0] exp_rx;
  logic        hold_read = 1'b0;
  logic        go;
  logic [7:0]  rnd = 8'h23;
  logic [7:0]  rr;
  int          gap = 0;
  int          err_count = 0;
  int          samples_checked = 0;

  always #12.5 clk = ~clk;

  async_serial_port async_serial_port_inst (
    .clk, .rst, .baud_div(16'h0000), .nine_bit_mode, .tx_enable, .send_break, .tx_ninth_bit,
    .rx_enable, .rx_standby_set, .wake_on_address, .data_write, .data_wdata, .data_read, .rx_buffer,
    .rx_ninth_bit, .tx_buffer_empty_flag, .tx_complete_flag, .rx_full_flag, .overrun_flag, .noise_flag,
    .framing_error_flag, .rx_standby, .txd, .rxd
  );

  remote_serial_model #(.BIT_CLKS(BIT)) remote_serial_model_inst (
    .clk, .txd, .nine_bit(nine_bit_mode), .rxd, .seen_valid, .seen_word
  );
  // ====================
  // helpers
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  task automatic wait_for(ref logic f, input logic lv);
    int k;
    k = 0;
    while (f !== lv && k < 5000) begin
      @(posedge clk);
      k++;
    end
    `CHECK("wait", lv, f)
  endtask

  task automatic tx_write(input byte_t d, input logic n);
    wait_for(tx_buffer_empty_flag, 1'b1);
    data_write <= 1'b1;
    data_wdata <= d;
    tx_ninth_bit <= n;
    tx_q.push_back({1'b1, n & nine_bit_mode, d});
    @(posedge clk);
    data_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rx_send(input logic [8:0] w, input int len, input logic g, input logic bs, input logic keep);
    if (keep) rx_q.push_back({bs, g, w[8] & nine_bit_mode, w[7:0]});
    remote_serial_model_inst.send(w, nine_bit_mode, len, g, bs);
  endtask

  task automatic drain;
    int k;
    k = 0;
    while ((rx_q.size() != 0 || tx_q.size() != 0) && k < 4000) begin
      @(posedge clk);
      k++;
    end
    `CHECK("drain", 0, rx_q.size() + tx_q.size())
  endtask

  task automatic end_sim;
    if (err_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ====================
  // monitors
  always @(posedge clk) begin
    if (seen_valid === 1'b1) begin
      exp_tx = tx_q.size() ? tx_q.pop_front() : 'x;
      `CHECK("tx_char", exp_tx, seen_word)
    end
  end

  always @(posedge clk) begin
    go = gap == 0 && rx_full_flag === 1'b1 && !hold_read;
    if (go) begin
      exp_rx = rx_q.size() ? rx_q.pop_front() : 'x;
      `CHECK("rx_char", exp_rx, {framing_error_flag, noise_flag, rx_ninth_bit, rx_buffer})
    end
    gap <= go ? 4 : (gap > 0 ? gap - 1 : 0);
    data_read <= go;
  end
  // ====================
  // stimulus
  initial begin
    int cnt;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rx_enable <= 1'b1;
    @(posedge clk);
    `CHECK("tx_empty", 1'b1, tx_buffer_empty_flag)
    tx_enable <= 1'b1;
    tx_write(8'h3c, 1'b0);
    cnt = 2;
    while (txd !== 1'b0 && cnt < 400) begin
      @(posedge clk);
      cnt++;
    end
    `CHECK("preamble", 1'b1, cnt >= 10 * BIT && cnt <= 12 * BIT + 4)
    for (int m = 0; m < 2; m++) begin
      wait_for(tx_complete_flag, 1'b1);
      nine_bit_mode <= m[0];
      rr = ~rnd;
      @(posedge clk);
      // transmitter and receiver run side by side
      fork
        begin
          for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            tx_write(rnd, rnd[0] ^ rnd[7]);
          end
          wait_for(tx_complete_flag, 1'b1);
          send_break <= 1'b1;
          wait_for(txd, 1'b0);
          send_break <= 1'b0;
          tx_q.push_back(10'h000);
          wait_for(tx_complete_flag, 1'b1);
        end
        for (int j = 0; j < 2; j++) begin
          rr = lfsr(rr);
          rx_send({rr[3], rr}, BIT, 1'b0, 1'b0, 1'b1);
        end
      join
    end
    nine_bit_mode <= 1'b0;
    @(posedge clk);
    // one bad sample, a bad stop, then a slow sender
    rx_send(9'h05a, BIT, 1'b1, 1'b0, 1'b1);
    rx_send(9'h03c, BIT, 1'b0, 1'b1, 1'b1);
    rx_send(9'h055, 18, 1'b0, 1'b0, 1'b1);
    hold_read <= 1'b1;
    for (int i = 0; i < 4; i++) rx_send({1'b0, 8'h40 + i[7:0]}, BIT, 1'b0, 1'b0, i < 3);
    `CHECK("overrun", 1'b1, overrun_flag)
    hold_read <= 1'b0;
    for (int w = 0; w < 2; w++) begin
      drain();
      wake_on_address <= w[0];
      rx_standby_set <= 1'b1;
      @(posedge clk);
      rx_standby_set <= 1'b0;
      @(posedge clk);
      `CHECK("standby", 1'b1, rx_standby)
      rx_send(9'h012, BIT, 1'b0, 1'b0, 1'b0);
      if (w == 0) wait_for(rx_standby, 1'b0);
      rx_send(9'h09c, BIT, 1'b0, 1'b0, 1'b1);
      `CHECK("awake", 1'b0, rx_standby)
    end
    drain();
    end_sim();
  end

  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    end_sim();
  end
endmodule // tb_async_serial_port
